//--- logic/i2crp_pkg.sv
// Constants and types shared by the two-wire register port.
// Assumes a core clock of 25 MHz and a link oversampling clock near 48 ns.
package i2crp_pkg;

  // Fixed upper six bits of the slave address; the low bit is the strap.
  localparam logic [5:0] DEV_ADDR_HI   = 6'h34;
  localparam logic       DIR_READ      = 1'b1;

  // Byte framing on the bus.
  localparam int         CNT_W         = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_ZERO      = 4'h0;
  localparam logic [3:0] CNT_ONE       = 4'h1;

  // Register pointer reset value and step.
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [7:0] PTR_STEP      = 8'h01;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // Bus rate limits: two-wire mode and the shared four-wire mode.
  localparam int BUS_MAX_KHZ           = 400;
  localparam int SPI_MAX_KHZ           = 1000;

  // Data setup before the clock is released after a stretch.
  localparam int DATA_SETUP_NS         = 100;
  localparam int LINK_PERIOD_NS        = 48;
  localparam int SETUP_CYCLES          = (DATA_SETUP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [3:0] SETUP_CNT     = 4'(SETUP_CYCLES);

  // Link-side protocol states.
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_PTR      = 4'h3,
    ST_PTR_ACK  = 4'h4,
    ST_WR       = 4'h5,
    ST_WR_ACK   = 4'h6,
    ST_WAIT     = 4'h7,
    ST_RD_TX    = 4'h8,
    ST_RD_ACK   = 4'h9
  } i2crp_state_t;

endpackage : i2crp_pkg

//--- logic/i2crp_sync.sv
// Two-flop level synchroniser, one per bit of the bus.
// Assumes inputs are levels that stay stable for several destination clocks.
`timescale 1ns/1ps
module i2crp_sync #(
  parameter int             WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Destination clock and synchronous reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Asynchronous level in, synchronised level out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : i2crp_sync

//--- logic/i2crp_slave.sv
// Two-wire slave port giving a bus master access to an internal register file.
// Assumes open-drain pads resolve the wires; the register file answers reads
// combinationally in the same core cycle as reg_rd.
`timescale 1ns/1ps

// Behaviour
// [R1] Address 110100 plus strap bit as LSB.
// [R2] Port is slave only, never masters.
// [R3] Works at any bus rate to 400 kHz.
// [R4] START while clock high begins address reception.
// [R5] STOP while clock high frees the bus.
// [R6] Repeated START restarts address decoding.
// [R7] Eight-bit bytes, unlimited bytes per transfer.
// [R8] Receiver pulls data low on ninth clock.
// [R9] Clock held low while access is pending.
// [R10] Address and direction bit, then acknowledge.
// [R11] Data changes only while clock is low.
// [R12] Write: address, pointer byte, data bytes stored.
// [R13] Burst write advances pointer each byte.
// [R14] Read after pointer write and repeated START.
// [R15] Master NACK ends the read.
// [R16] Pins shared with four-wire serial port.
// [R17] Host disables two-wire mode when using SPI.
// [R18] Foreign addresses ignored until next START.
// [R19] Burst read advances pointer each byte.
module i2crp_slave (
  // Core clock domain.
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Link oversampling clock.
  input  wire logic       link_clk,
  // Bus clock pin: input, output and active-low output enable.
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  // Bus data pin: input, output and active-low output enable.
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Address select strap, shared with the four-wire data output.
  input  wire logic       address_select_pin,
  // Core-side configuration level.
  input  wire logic       two_wire_port_disable,
  // Register file access, core domain.
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);

  // Link-domain state.
  logic                       link_rst_n;
  logic [4:0]                 link_sync;
  logic                       s_scl;
  logic                       s_sda;
  logic                       s_strap;
  logic                       s_disable;
  logic                       s_ack_tog;
  logic                       scl_d_reg;
  logic                       sda_d_reg;
  i2crp_pkg::i2crp_state_t    state_reg;
  logic [i2crp_pkg::CNT_W-1:0] cnt_reg;
  logic [7:0]                 shift_reg;
  logic [7:0]                 ptr_reg;
  logic                       dir_reg;
  logic                       mack_reg;
  logic                       req_tog_reg;
  logic                       req_read_reg;
  logic [7:0]                 xfer_addr_reg;
  logic [7:0]                 xfer_data_reg;
  logic [3:0]                 su_cnt_reg;

  // Core-domain state.
  logic                       s_req_tog;
  logic                       req_seen_reg;
  logic                       ack_tog_reg;
  logic [7:0]                 rdata_hold_reg;

  // Decoded link events.
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy;
  logic byte_done;
  logic issue_wr;
  logic issue_rd;
  logic req_edge;

  // Pointer increment, shared by write and read bursts.
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = p + i2crp_pkg::PTR_STEP;
  endfunction : ptr_inc

  // Reset is carried into the link domain through two flops.
  i2crp_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_rst_sync (
    .clk      (link_clk),
    .rst_n    (1'b1),
    .async_in (reset_n),
    .sync_out (link_rst_n)
  );

  // Pins, strap, disable level and the acknowledge toggle enter the link domain.
  i2crp_sync #(
    .WIDTH     (5),
    .RESET_VAL (5'h03)
  ) u_link_sync (
    .clk      (link_clk),
    .rst_n    (link_rst_n),
    .async_in ({ack_tog_reg, two_wire_port_disable, address_select_pin, sda_in, scl_in}),
    .sync_out (link_sync)
  );

  assign s_scl     = link_sync[0];
  assign s_sda     = link_sync[1];
  assign s_strap   = link_sync[2]; // [R16]
  assign s_disable = link_sync[3];
  assign s_ack_tog = link_sync[4];

  // The request toggle enters the core domain through two flops.
  i2crp_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_core_sync (
    .clk      (core_clk),
    .rst_n    (reset_n),
    .async_in (req_tog_reg),
    .sync_out (s_req_tog)
  );

  // Previous samples of the synchronised wires for edge detection.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= s_scl;
      sda_d_reg <= s_sda;
    end
  end

  // Bus events; start and stop only count while the clock stays high.
  assign scl_rise  = s_scl & ~scl_d_reg;
  assign scl_fall  = ~s_scl & scl_d_reg;
  assign start_det = s_scl & scl_d_reg & sda_d_reg & ~s_sda; // [R4] [R6]
  assign stop_det  = s_scl & scl_d_reg & ~sda_d_reg & s_sda; // [R5]
  assign busy      = req_tog_reg ^ s_ack_tog;
  assign byte_done = scl_fall & (cnt_reg == i2crp_pkg::BITS_PER_BYTE); // [R7]

  // Register accesses are launched at byte boundaries.
  assign issue_wr = ~start_det & ~stop_det & (state_reg == i2crp_pkg::ST_WR) & byte_done;
  assign issue_rd = ~start_det & ~stop_det & scl_fall &
                    (((state_reg == i2crp_pkg::ST_ADDR_ACK) &&
                      (dir_reg == i2crp_pkg::DIR_READ)) ||
                     ((state_reg == i2crp_pkg::ST_RD_ACK) && !mack_reg)); // [R14] [R15]

  // Protocol sequencer. The port never starts a transfer; it only follows.
  always_ff @(posedge link_clk) begin // [R2]
    if (!link_rst_n || s_disable) begin // [R17]
      state_reg <= i2crp_pkg::ST_IDLE;
      cnt_reg   <= i2crp_pkg::CNT_ZERO;
      shift_reg <= i2crp_pkg::BYTE_ZERO;
      dir_reg   <= 1'b0;
      mack_reg  <= 1'b1;
    end else if (start_det) begin
      state_reg <= i2crp_pkg::ST_ADDR; // [R4] [R6]
      cnt_reg   <= i2crp_pkg::CNT_ZERO;
    end else if (stop_det) begin
      state_reg <= i2crp_pkg::ST_IDLE; // [R5]
    end else begin
      case (state_reg)
        i2crp_pkg::ST_ADDR, i2crp_pkg::ST_PTR, i2crp_pkg::ST_WR: begin
          // Sample on the rising clock, act after the eighth falling clock.
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], s_sda};
            cnt_reg   <= cnt_reg + i2crp_pkg::CNT_ONE;
          end else if (byte_done) begin
            cnt_reg <= i2crp_pkg::CNT_ZERO;
            if (state_reg == i2crp_pkg::ST_ADDR) begin
              if (shift_reg[7:1] == {i2crp_pkg::DEV_ADDR_HI, s_strap}) begin // [R1] [R10]
                state_reg <= i2crp_pkg::ST_ADDR_ACK;
                dir_reg   <= shift_reg[0];
              end else begin
                state_reg <= i2crp_pkg::ST_IDLE; // [R18]
              end
            end else if (state_reg == i2crp_pkg::ST_PTR) begin
              state_reg <= i2crp_pkg::ST_PTR_ACK; // [R12]
            end else begin
              state_reg <= i2crp_pkg::ST_WR_ACK; // [R12]
            end
          end
        end
        i2crp_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            state_reg <= (dir_reg == i2crp_pkg::DIR_READ) ? i2crp_pkg::ST_WAIT
                                                         : i2crp_pkg::ST_PTR;
          end
        end
        i2crp_pkg::ST_PTR_ACK: begin
          if (scl_fall) begin
            state_reg <= i2crp_pkg::ST_WR;
          end
        end
        i2crp_pkg::ST_WR_ACK: begin
          // A write still in flight stretches the clock before the next byte.
          if (scl_fall) begin
            state_reg <= busy ? i2crp_pkg::ST_WAIT : i2crp_pkg::ST_WR; // [R9]
          end
        end
        i2crp_pkg::ST_WAIT: begin
          if (!busy) begin // [R9]
            if (req_read_reg) begin
              shift_reg <= rdata_hold_reg;
              cnt_reg   <= i2crp_pkg::CNT_ZERO;
              state_reg <= i2crp_pkg::ST_RD_TX;
            end else begin
              state_reg <= i2crp_pkg::ST_WR;
            end
          end
        end
        i2crp_pkg::ST_RD_TX: begin
          // Next bit is presented only after the falling clock.
          if (scl_rise) begin
            cnt_reg <= cnt_reg + i2crp_pkg::CNT_ONE;
          end else if (byte_done) begin
            cnt_reg   <= i2crp_pkg::CNT_ZERO;
            state_reg <= i2crp_pkg::ST_RD_ACK;
          end else if (scl_fall) begin
            shift_reg <= {shift_reg[6:0], 1'b0}; // [R11]
          end
        end
        i2crp_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            mack_reg <= s_sda;
          end else if (scl_fall) begin
            state_reg <= mack_reg ? i2crp_pkg::ST_IDLE : i2crp_pkg::ST_WAIT; // [R15]
          end
        end
        default: begin
          state_reg <= i2crp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Register pointer: loaded by the pointer byte, bumped by every access.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      ptr_reg <= i2crp_pkg::PTR_RESET;
    end else if (state_reg == i2crp_pkg::ST_PTR && byte_done && !start_det && !stop_det) begin
      ptr_reg <= shift_reg; // [R12]
    end else if (issue_wr || issue_rd) begin
      ptr_reg <= ptr_inc(ptr_reg); // [R13] [R19]
    end
  end

  // Request toggle with address and data held stable until acknowledged.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      req_tog_reg   <= 1'b0;
      req_read_reg  <= 1'b0;
      xfer_addr_reg <= i2crp_pkg::BYTE_ZERO;
      xfer_data_reg <= i2crp_pkg::BYTE_ZERO;
    end else if (issue_wr) begin
      req_tog_reg   <= ~req_tog_reg;
      req_read_reg  <= 1'b0;
      xfer_addr_reg <= ptr_reg;
      xfer_data_reg <= shift_reg; // [R12] [R13]
    end else if (issue_rd) begin
      req_tog_reg   <= ~req_tog_reg;
      req_read_reg  <= 1'b1;
      xfer_addr_reg <= ptr_reg; // [R14] [R19]
    end
  end

  // After a stretch, data gets a setup margin before the clock is freed.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      su_cnt_reg <= i2crp_pkg::SETUP_CNT;
    end else if (state_reg == i2crp_pkg::ST_WAIT) begin
      su_cnt_reg <= i2crp_pkg::CNT_ZERO;
    end else if (su_cnt_reg != i2crp_pkg::SETUP_CNT) begin
      su_cnt_reg <= su_cnt_reg + i2crp_pkg::CNT_ONE;
    end
  end

  // Pin drivers. Only low is ever driven; the pull-ups make the high level.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      sda_out  <= 1'b0;
      scl_out  <= 1'b0;
    end else begin
      sda_out  <= 1'b0;
      scl_out  <= 1'b0;
      sda_oe_n <= ~(~s_disable &
                    ((state_reg == i2crp_pkg::ST_ADDR_ACK) ||
                     (state_reg == i2crp_pkg::ST_PTR_ACK) ||
                     (state_reg == i2crp_pkg::ST_WR_ACK) ||
                     ((state_reg == i2crp_pkg::ST_RD_TX) && !shift_reg[7]))); // [R8] [R11]
      scl_oe_n <= ~(~s_disable &
                    ((state_reg == i2crp_pkg::ST_WAIT) ||
                     (su_cnt_reg != i2crp_pkg::SETUP_CNT))); // [R9] [R3]
    end
  end

  // Core side: one access pulse per request, then the toggle is returned.
  assign req_edge = s_req_tog ^ req_seen_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      req_seen_reg   <= 1'b0;
      reg_wr         <= 1'b0;
      reg_rd         <= 1'b0;
      reg_addr       <= i2crp_pkg::BYTE_ZERO;
      reg_wdata      <= i2crp_pkg::BYTE_ZERO;
    end else begin
      req_seen_reg <= s_req_tog;
      reg_wr       <= req_edge & ~req_read_reg; // [R12]
      reg_rd       <= req_edge & req_read_reg; // [R14]
      if (req_edge) begin
        reg_addr  <= xfer_addr_reg;
        reg_wdata <= xfer_data_reg;
      end
    end
  end

  // Read data are held for the link, and the acknowledge toggle closes the loop.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ack_tog_reg    <= 1'b0;
      rdata_hold_reg <= i2crp_pkg::BYTE_ZERO;
    end else begin
      if (reg_rd) begin
        rdata_hold_reg <= reg_rdata;
      end
      if (reg_wr || reg_rd) begin
        ack_tog_reg <= ~ack_tog_reg;
      end
    end
  end

endmodule : i2crp_slave

//--- dv/i2crp_slave_assertions.sv
// Concurrent checks on the two-wire register port pins and core strobes.
// Assumes it is bound to every instance of the port's top module.
`timescale 1ns/1ps
module i2crp_slave_chk (
  // Clocks and reset.
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       link_clk,
  // Bus pins.
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_n,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // Strap and disable.
  input wire logic       address_select_pin,
  input wire logic       two_wire_port_disable,
  // Register file side.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  logic [3:0] dis_cnt_reg;
  // Counts link cycles of a held disable, so its synchroniser has settled.
  always_ff @(posedge link_clk) begin
    if (!reset_n || !two_wire_port_disable) begin
      dis_cnt_reg <= 4'h0;
    end else if (dis_cnt_reg != 4'hf) begin
      dis_cnt_reg <= dis_cnt_reg + 4'h1;
    end
  end
  // A stretch must end within a bounded wait, or the master hangs.
  sequence s_release;
    ##[1:400] scl_oe_n;
  endsequence
  a_pins_pull_low: assert property (@(posedge link_clk) disable iff (!reset_n)
    !scl_out && !sda_out) else $error("bus pin driven high");
  a_disable_quiet: assert property (@(posedge link_clk) disable iff (!reset_n)
    dis_cnt_reg == 4'hf |-> sda_oe_n && scl_oe_n) else $error("pins driven while off");
  a_sda_clk_low: assert property (@(posedge link_clk) disable iff (!reset_n)
    $changed(sda_oe_n) |-> !scl_in) else $error("data moved with clock high");
  a_stretch_low: assert property (@(posedge link_clk) disable iff (!reset_n)
    $fell(scl_oe_n) |-> !$past(scl_in)) else $error("stretch began with clock high");
  a_stretch_ends: assert property (@(posedge link_clk) disable iff (!reset_n)
    $fell(scl_oe_n) |-> s_release) else $error("clock held too long");
  a_wr_single: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_wr |=> !reg_wr [*8]) else $error("write strobe too long");
  a_rd_single: assert property (@(posedge core_clk) disable iff (!reset_n)
    reg_rd |=> !reg_rd [*8]) else $error("read strobe too long");
  a_one_access: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(reg_wr && reg_rd)) else $error("read and write together");
  a_addr_stands: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(reg_wr || reg_rd) |-> $stable(reg_addr)) else $error("address moved idle");
endmodule : i2crp_slave_chk

bind i2crp_slave i2crp_slave_chk i_chk (
  .core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin),
  .two_wire_port_disable(two_wire_port_disable), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

//--- dv/i2crp_master_model.sv
// Bus master model for the two-wire port, driving open-drain wires.
// Assumes the bench resolves the wires with pull-ups and feeds them back.
`timescale 1ns/1ps
module i2crp_master_model #(
  parameter int QUARTER = 18
) (
  // Clock that paces the bus phases.
  input  wire logic clk,
  // Resolved wire levels.
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Open-drain drives: 1 releases the wire.
  output logic      scl_drv,
  output logic      sda_drv,
  // Raised when the device holds the clock too long.
  output logic      hung
);
  // Both wires idle released.
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    hung    = 1'b0;
  end
  // A third of a bit; three of them and one clock make a 2200 ns bit, faster than the 400 kHz top rate.
  task automatic pause();
    repeat (QUARTER) @(posedge clk);
  endtask : pause
  // Releases the clock and waits while the device stretches it.
  task automatic rise();
    int n;
    scl_drv <= 1'b1;
    n = 0;
    @(posedge clk);
    while (scl_in !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      hung <= 1'b1;
    end
    pause();
  endtask : rise
  // One bit: data set while the clock is low, sampled at the end of the high phase.
  task automatic bit_xfer(input logic b, output logic r);
    sda_drv <= b;
    pause();
    rise();
    r = sda_in;
    scl_drv <= 1'b0;
    pause();
  endtask : bit_xfer
  // Start or repeated start.
  task automatic start();
    sda_drv <= 1'b1;
    pause();
    rise();
    sda_drv <= 1'b0;
    pause();
    scl_drv <= 1'b0;
    pause();
  endtask : start
  task automatic stop();
    sda_drv <= 1'b0;
    pause();
    rise();
    sda_drv <= 1'b1;
    pause();
  endtask : stop
  // Eight bits then a released ninth bit for the device's answer.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  // Eight bits in, then acknowledge, or leave high on the last byte.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(last, r);
  endtask : rd_byte
endmodule : i2crp_master_model

//--- dv/tb.sv
// Self-checking bench for the two-wire register port with a register file model.
// Assumes the master model paces bus phases from the core clock.
`timescale 1ns/1ps
module tb;
  logic       core_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       reset_n  = 1'b0;
  logic       address_select_pin, two_wire_port_disable, scl_drv, sda_drv, hung;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, reg_wr, reg_rd, scl_w, sda_w;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] mem [256];
  int         bad_count    = 0;
  int         total_checks = 0;
  int         rd_count     = 0;

  // Two unrelated clocks.
  always #20 core_clk = ~core_clk;
  always #24 link_clk = ~link_clk;
  // Pulled-up wires; a low from any party wins.
  assign scl_w = scl_drv & (scl_oe_n | scl_out);
  assign sda_w = sda_drv & (sda_oe_n | sda_out);
  // Register file answers a read in the same cycle.
  assign reg_rdata = mem[reg_addr];
  always @(posedge core_clk) begin
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
    end
    if (reg_rd) begin
      rd_count <= rd_count + 1;
    end
  end

  i2crp_slave i_i2crp_slave (.core_clk(core_clk), .reset_n(reset_n), .link_clk(link_clk),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin),
    .two_wire_port_disable(two_wire_port_disable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  i2crp_master_model #(.QUARTER(18)) i_i2crp_master_model (.clk(core_clk), .scl_in(scl_w),
    .sda_in(sda_w), .scl_drv(scl_drv), .sda_drv(sda_drv), .hung(hung));

  task automatic summarize();
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic chk_ack(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: answer bit %b, wanted %b", $time, got, exp);
    end
  endtask : chk_ack
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
  endtask : chk_byte
  // Start, then an address byte whose answer is compared.
  task automatic send_addr(input logic [6:0] a, input logic rd, input logic exp);
    logic ack;
    i_i2crp_master_model.start();
    i_i2crp_master_model.wr_byte({a, rd}, ack);
    chk_ack(ack, exp);
  endtask : send_addr
  function automatic logic [6:0] own(input logic s);
    return {i2crp_pkg::DEV_ADDR_HI, s};
  endfunction : own
  // Burst of three writes; a pointer near the top wraps round.
  task automatic t_write(input logic s, input logic [7:0] ptr);
    logic       ack;
    logic [7:0] a;
    address_select_pin <= s;
    repeat (8) @(posedge core_clk);
    send_addr(own(s), 1'b0, 1'b1);
    i_i2crp_master_model.wr_byte(ptr, ack);
    chk_ack(ack, 1'b1);
    for (int i = 0; i < 3; i++) begin
      a = ptr + 8'(i);
      i_i2crp_master_model.wr_byte(~a, ack);
      chk_ack(ack, 1'b1);
    end
    i_i2crp_master_model.stop();
    repeat (20) @(posedge core_clk);
    for (int i = 0; i < 3; i++) begin
      a = ptr + 8'(i);
      chk_byte(mem[a], ~a);
    end
  endtask : t_write
  // Pointer write, repeated start, burst read of three ending on a refusal.
  task automatic t_read(input logic s, input logic [7:0] ptr);
    logic       ack;
    logic [7:0] d;
    int         n0;
    address_select_pin <= s;
    n0 = rd_count;
    repeat (8) @(posedge core_clk);
    send_addr(own(s), 1'b0, 1'b1);
    i_i2crp_master_model.wr_byte(ptr, ack);
    chk_ack(ack, 1'b1);
    send_addr(own(s), 1'b1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      i_i2crp_master_model.rd_byte(i == 2, d);
      chk_byte(d, mem[8'(ptr + 8'(i))]);
    end
    i_i2crp_master_model.stop();
    // A refused last byte must not trigger a further fetch.
    repeat (20) @(posedge core_clk);
    chk_byte(8'(rd_count - n0), 8'h03);
  endtask : t_read
  // The other strap address is ignored until a repeated start names this one.
  task automatic t_foreign();
    logic ack;
    address_select_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    send_addr(own(1'b1), 1'b0, 1'b0);
    i_i2crp_master_model.wr_byte(8'h10, ack);
    chk_ack(ack, 1'b0);
    send_addr(own(1'b0), 1'b0, 1'b1);
    i_i2crp_master_model.wr_byte(8'h40, ack);
    i_i2crp_master_model.wr_byte(8'h5a, ack);
    i_i2crp_master_model.stop();
    repeat (20) @(posedge core_clk);
    chk_byte(mem[8'h40], 8'h5a);
  endtask : t_foreign
  // With the port disabled its own address gets no answer.
  task automatic t_disabled();
    two_wire_port_disable <= 1'b1;
    repeat (20) @(posedge core_clk);
    send_addr(own(1'b0), 1'b0, 1'b0);
    i_i2crp_master_model.stop();
    two_wire_port_disable <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask : t_disabled

  // A stuck clock ends the run.
  always @(posedge hung) begin
    bad_count++;
    summarize();
  end
  // Main sequence.
  initial begin
    address_select_pin    <= 1'b0;
    two_wire_port_disable <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    t_write(1'b0, 8'h10);
    t_write(1'b1, 8'hfe);
    t_read(1'b1, 8'hfe);
    t_read(1'b0, 8'h80);
    t_foreign();
    t_disabled();
    summarize();
  end
endmodule : tb
